// File: fesig_core.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - ten fault sources can start emergency signalling
// - a set mask bit blocks its fault from tone and error pin
// - masked faults are still recorded in the diagnostic register
// - after the tone, return to sleep or normal as before
// - diagnostic bits latch; cleared by controller or top cell supply loss
// - diagnostic bits kept through sleep entry and exit
// - each periodic scan outside a running tone restarts the tone while an unmasked fault stays
// - measurement lock from failed wake check blocks scan-started tones; received tones are still relayed
// - error pin enable activates the pin and suppresses scan-started chain tone; received tones are still relayed
// - enabled error pin goes high on any unmasked fault
// - error pin stays high until faults are cleared or masked
// - error pin held low during sleep
// - error pin rises again after sleep if fault still latched
// - emergency tone is 50 kHz for exactly 32 periods
// - while forwarding wake-up, detect tone after 4 periods
// - idle and unenumerated, detect tone after 16 periods
// - sleeping device takes tone as wake-up, then extends it awake
// - in normal operation only receiving ports accept the tone
module fesig_core (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // fault sources and controller access
   input wire fesig_pkg::fesig_fault_t fault_event_i,
   input wire fesig_pkg::fesig_fault_t diag_clear_i,
   input wire fesig_pkg::fesig_fault_t fault_mask_i,
   input wire logic err_pin_en_i,
   // power and scan state
   input wire logic top_cell_supply_i,
   input wire logic sleep_i,
   input wire logic periodic_scan_tick_i,
   input wire logic wake_check_fail_i,
   input wire logic lock_release_i,
   // chain state
   input wire logic normal_op_i,
   input wire logic forwarding_wakeup_i,
   input wire fesig_pkg::fesig_chain_s port_is_rx_i,
   input wire fesig_pkg::fesig_chain_s chain_rx_i,
   // chain drive
   output logic upper_chain_tx_o,
   output logic upper_chain_oe_o,
   output logic lower_chain_tx_o,
   output logic lower_chain_oe_o,
   // status
   output logic err_pin_o,
   output fesig_pkg::fesig_fault_t general_diagnostic_reg_o,
   output logic measurement_lock_o,
   output logic wake_request_o,
   output logic return_sleep_o,
   output logic return_normal_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   fesig_pkg::fesig_regs_s r_reg;
   fesig_pkg::fesig_regs_s r_next;
   fesig_pkg::fesig_fault_t unmasked;
   logic fault_trig;
   logic own_start;
   logic rx_detect;
   logic [1:0] rx_edge;
   logic [1:0] rx_accept;
   logic [4:0] rx_thr;

   assign unmasked = r_reg.diag & ~fault_mask_i;
   assign fault_trig = |unmasked;
   // own tone only from a scan, never under lock or with the error pin
   assign own_start = periodic_scan_tick_i & fault_trig & ~r_reg.lock
                      & ~err_pin_en_i;
   assign rx_accept = {~normal_op_i | port_is_rx_i.upper,
                       ~normal_op_i | port_is_rx_i.lower};
   assign rx_edge = r_reg.rx_s2 & ~r_reg.rx_d & rx_accept;
   assign rx_thr = forwarding_wakeup_i ? 5'(fesig_pkg::DETECT_WAKE_PERIODS)
                                       : 5'(fesig_pkg::DETECT_IDLE_PERIODS);

   always_comb
   begin
      r_next = r_reg;
      r_next.wake_req = 1'b0;
      r_next.back_sleep = 1'b0;
      r_next.back_normal = 1'b0;
      rx_detect = 1'b0;

      // ------------------------------------------------------------
      // synchronisers
      // ------------------------------------------------------------
      r_next.sup_s1 = top_cell_supply_i;
      r_next.sup_s2 = r_reg.sup_s1;
      r_next.rx_s1 = {chain_rx_i.upper, chain_rx_i.lower};
      r_next.rx_s2 = r_reg.rx_s1;
      r_next.rx_d = r_reg.rx_s2;

      // ------------------------------------------------------------
      // diagnostic latch and lock
      // ------------------------------------------------------------
      if (!r_reg.sup_s2)
      begin
         r_next.diag = fesig_pkg::DIAG_RESET;
      end
      else
      begin
         // set beats clear; sleep has no effect here
         r_next.diag = (r_reg.diag & ~diag_clear_i) | fault_event_i;
      end
      if (wake_check_fail_i)
      begin
         r_next.lock = 1'b1;
      end
      else if (lock_release_i)
      begin
         r_next.lock = 1'b0;
      end

      // ------------------------------------------------------------
      // error pin
      // ------------------------------------------------------------
      r_next.err = err_pin_en_i & ~sleep_i & fault_trig;

      // ------------------------------------------------------------
      // received tone counting
      // ------------------------------------------------------------
      for (int p = 0; p < 2; p++)
      begin
         if (rx_edge[p])
         begin
            r_next.gap[p] = 12'h000;
            if (r_reg.rx_cnt[p] != 5'h1F)
            begin
               r_next.rx_cnt[p] = r_reg.rx_cnt[p] + 5'h01;
            end
         end
         else if (r_reg.gap[p] == 12'(fesig_pkg::RX_GAP_CYC - 1))
         begin
            r_next.rx_cnt[p] = 5'h00;
         end
         else
         begin
            r_next.gap[p] = r_reg.gap[p] + 12'h001;
         end
         if (!sleep_i && r_reg.rx_cnt[p] >= rx_thr)
         begin
            rx_detect = 1'b1;
         end
      end
      if (sleep_i && |rx_edge)
      begin
         r_next.wake_req = 1'b1;
      end

      // ------------------------------------------------------------
      // tone generator
      // ------------------------------------------------------------
      unique case (r_reg.state)
         fesig_pkg::ST_IDLE:
         begin
            if (own_start || rx_detect)
            begin
               r_next.state = fesig_pkg::ST_TONE;
               r_next.half = 10'h000;
               r_next.per = 6'h00;
               r_next.tone = 1'b1;
               r_next.was_sleep = sleep_i;
               r_next.rx_cnt = '0;
            end
         end
         fesig_pkg::ST_TONE:
         begin
            r_next.rx_cnt = '0;
            if (r_reg.half == 10'(fesig_pkg::TONE_HALF_CYC - 1))
            begin
               r_next.half = 10'h000;
               r_next.tone = ~r_reg.tone;
               if (!r_reg.tone)
               begin
                  if (r_reg.per == 6'(fesig_pkg::EMERGENCY_LENGTH_PERIODS - 1))
                  begin
                     r_next.state = fesig_pkg::ST_IDLE;
                     r_next.tone = 1'b0;
                     r_next.back_sleep = r_reg.was_sleep;
                     r_next.back_normal = ~r_reg.was_sleep;
                  end
                  else
                  begin
                     r_next.per = r_reg.per + 6'h01;
                  end
               end
            end
            else
            begin
               r_next.half = r_reg.half + 10'h001;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign upper_chain_tx_o = r_reg.tone;
   assign lower_chain_tx_o = r_reg.tone;
   assign upper_chain_oe_o = (r_reg.state == fesig_pkg::ST_TONE);
   assign lower_chain_oe_o = (r_reg.state == fesig_pkg::ST_TONE);
   assign err_pin_o = r_reg.err;
   assign general_diagnostic_reg_o = r_reg.diag;
   assign measurement_lock_o = r_reg.lock;
   assign wake_request_o = r_reg.wake_req;
   assign return_sleep_o = r_reg.back_sleep;
   assign return_normal_o = r_reg.back_normal;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [15:0] chk_cyc;
   logic [5:0] chk_rise;

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         chk_cyc <= 16'h0000;
         chk_rise <= 6'h00;
      end
      else if (!upper_chain_oe_o)
      begin
         chk_cyc <= 16'h0000;
         chk_rise <= 6'h00;
      end
      else
      begin
         chk_cyc <= chk_cyc + 16'h0001;
         chk_rise <= chk_rise + 6'(r_next.tone & ~r_reg.tone);
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_diag_latch_hold: assert property (
      r_reg.sup_s2 && diag_clear_i == '0
      |=> (general_diagnostic_reg_o & $past(general_diagnostic_reg_o))
          == $past(general_diagnostic_reg_o))
      else $error("diagnostic bit dropped without clear");
   a_masked_recorded: assert property (
      r_reg.sup_s2 |=> (general_diagnostic_reg_o & $past(fault_event_i))
                       == $past(fault_event_i))
      else $error("fault event not recorded");
   a_supply_loss_clear: assert property (
      !r_reg.sup_s2 |=> general_diagnostic_reg_o == '0)
      else $error("supply loss did not clear diagnostics");
   a_err_pin_high: assert property (
      err_pin_en_i && !sleep_i && fault_trig |=> err_pin_o)
      else $error("error pin not raised on unmasked fault");
   a_err_pin_sleep: assert property (
      sleep_i |=> !err_pin_o)
      else $error("error pin high during sleep");
   a_err_pin_masked: assert property (
      !fault_trig |=> !err_pin_o)
      else $error("error pin high without unmasked fault");
   a_errpin_no_tone: assert property (
      r_reg.state == fesig_pkg::ST_IDLE && err_pin_en_i && !rx_detect
      |=> !upper_chain_oe_o)
      else $error("own tone sent with error pin enabled");
   a_lock_no_tone: assert property (
      r_reg.state == fesig_pkg::ST_IDLE && r_reg.lock && !rx_detect
      |=> !upper_chain_oe_o)
      else $error("tone started under measurement lock");
   a_scan_retrigger: assert property (
      r_reg.state == fesig_pkg::ST_IDLE && periodic_scan_tick_i && !r_reg.lock
      && !err_pin_en_i && fault_trig |=> upper_chain_oe_o && upper_chain_tx_o)
      else $error("scan did not restart tone");
   a_tone_length: assert property (
      $fell(upper_chain_oe_o) |-> $past(chk_cyc) == 16'(fesig_pkg::TONE_TOTAL_CYC - 1)
                                  && $past(chk_rise)
                                     == 6'(fesig_pkg::EMERGENCY_LENGTH_PERIODS - 1))
      else $error("tone length wrong");
   a_mode_return: assert property (
      $fell(upper_chain_oe_o) |-> return_sleep_o != return_normal_o)
      else $error("no mode return after tone");
   a_sleep_wake: assert property (
      sleep_i && |rx_edge |=> wake_request_o)
      else $error("tone in sleep not taken as wake-up");

   c_own_tone: cover property (own_start && r_reg.state == fesig_pkg::ST_IDLE);
   c_rx_tone: cover property (rx_detect && r_reg.state == fesig_pkg::ST_IDLE);
   c_err_pin: cover property ($rose(err_pin_o));
   c_back_sleep: cover property (return_sleep_o);

endmodule

`default_nettype wire

// File: fesig_pkg.sv
package fesig_pkg;

   // ------------------------------------------------------------
   // fault sources
   // ------------------------------------------------------------
   localparam int unsigned NUM_FAULTS = 10;
   localparam int unsigned FLT_CELL_OV = 0;
   localparam int unsigned FLT_CELL_UV = 1;
   localparam int unsigned FLT_EXT_TEMP = 2;
   localparam int unsigned FLT_OPEN_LOAD = 3;
   localparam int unsigned FLT_BAL_OC = 4;
   localparam int unsigned FLT_BAL_UC = 5;
   localparam int unsigned FLT_CONV_XCHK = 6;
   localparam int unsigned FLT_INT_TEMP = 7;
   localparam int unsigned FLT_REG_CRC = 8;
   localparam int unsigned FLT_INT_IC = 9;

   typedef logic [NUM_FAULTS-1:0] fesig_fault_t;
   localparam fesig_fault_t DIAG_RESET = 10'h000;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ = 100_000_000;
   localparam int unsigned EMERGENCY_TONE_FREQUENCY_HZ = 50_000;
   localparam int unsigned TONE_HALF_CYC = CLK_FREQ_HZ / (2 * EMERGENCY_TONE_FREQUENCY_HZ);
   localparam int unsigned EMERGENCY_LENGTH_PERIODS = 32;
   localparam int unsigned DETECT_WAKE_PERIODS = 4;
   localparam int unsigned DETECT_IDLE_PERIODS = 16;
   // received tone counts as broken after one and a half periods silence
   localparam int unsigned RX_GAP_CYC = 3 * TONE_HALF_CYC;
   localparam int unsigned TONE_TOTAL_CYC = EMERGENCY_LENGTH_PERIODS * 2 * TONE_HALF_CYC;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic upper;
      logic lower;
   } fesig_chain_s;

   typedef enum logic {
      ST_IDLE,
      ST_TONE
   } fesig_state_e;

   typedef struct packed {
      fesig_state_e state;
      fesig_fault_t diag;
      logic lock;
      logic sup_s1;
      logic sup_s2;
      logic [1:0] rx_s1;
      logic [1:0] rx_s2;
      logic [1:0] rx_d;
      logic [1:0][11:0] gap;
      logic [1:0][4:0] rx_cnt;
      logic [9:0] half;
      logic [5:0] per;
      logic tone;
      logic was_sleep;
      logic err;
      logic wake_req;
      logic back_sleep;
      logic back_normal;
   } fesig_regs_s;

endpackage

// File: fesig_tone_src.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// neighbour device sending an emergency tone into the chain
// ------------------------------------------------------------
module fesig_tone_src (
   // clock
   input wire logic clk_i,
   // control from the bench
   input wire logic start_i,
   input wire logic [5:0] periods_i,
   input wire fesig_pkg::fesig_chain_s sel_i,
   // chain line toward the block
   output fesig_pkg::fesig_chain_s rx_o,
   output logic busy_o
);
   logic [16:0] t_reg;
   logic [16:0] len;
   logic lvl;

   initial busy_o = 1'b0;
   initial t_reg = 17'h00000;

   // whole periods, high half first
   assign len = 17'(periods_i) * 17'(2 * fesig_pkg::TONE_HALF_CYC);
   assign lvl = busy_o && ((32'(t_reg) / fesig_pkg::TONE_HALF_CYC) % 2 == 0);
   // line rests low between frames
   assign rx_o = '{upper: lvl & sel_i.upper, lower: lvl & sel_i.lower};

   // starts on the rising edge so a request set at the falling edge is seen once
   always @(posedge clk_i)
   begin
      if (busy_o)
      begin
         t_reg <= t_reg + 17'h00001;
         if (t_reg == len - 17'h00001)
         begin
            busy_o <= 1'b0;
         end
      end
      else if (start_i)
      begin
         busy_o <= 1'b1;
         t_reg <= 17'h00000;
      end
   end
endmodule

`default_nettype wire

// File: test_fault_emergency_signaling.sv
`timescale 1ns/1ps
`default_nettype none

module test_fault_emergency_signaling;
   logic clk = 1'b0;
   logic rst = 1'b1;
   fesig_pkg::fesig_fault_t ev = '0, clr = '0, msk = '0, diag;
   logic en = 1'b0, sup = 1'b1, slp = 1'b0, scan = 1'b0, wfail = 1'b0, lrel = 1'b0;
   logic nop = 1'b0, fwd = 1'b0, go = 1'b0, busy;
   fesig_pkg::fesig_chain_s prx = 2'h3, sel = 2'h2, rx;
   logic utx, uoe, ltx, loe, err, lock, wreq, rsl, rnm;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc, per;
   logic prev;

   always #5 clk = ~clk;

   fesig_core u_dut (.clk_i(clk), .sys_rst_i(rst), .fault_event_i(ev), .diag_clear_i(clr),
      .fault_mask_i(msk), .err_pin_en_i(en), .top_cell_supply_i(sup), .sleep_i(slp),
      .periodic_scan_tick_i(scan), .wake_check_fail_i(wfail), .lock_release_i(lrel),
      .normal_op_i(nop), .forwarding_wakeup_i(fwd), .port_is_rx_i(prx), .chain_rx_i(rx),
      .upper_chain_tx_o(utx), .upper_chain_oe_o(uoe), .lower_chain_tx_o(ltx),
      .lower_chain_oe_o(loe), .err_pin_o(err), .general_diagnostic_reg_o(diag),
      .measurement_lock_o(lock), .wake_request_o(wreq), .return_sleep_o(rsl),
      .return_normal_o(rnm));

   fesig_tone_src u_src (.clk_i(clk), .start_i(go), .periods_i(6'h04), .sel_i(sel),
      .rx_o(rx), .busy_o(busy));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic do_reset;
      rst = 1'b1;
      tick(4);
      rst = 1'b0;
      tick(3);
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_err_pin;
      en = 1'b1;
      msk = 10'h200;
      ev = 10'h200;
      tick(1);
      ev = '0;
      tick(2);
      chk({6'h00, diag}, 16'h0200);
      chk(err, 1'b0);
      msk = '0;
      tick(2);
      chk(err, 1'b1);
      slp = 1'b1;
      tick(2);
      chk({err, diag}, 11'h200);
      slp = 1'b0;
      tick(2);
      chk(err, 1'b1);
      clr = 10'h200;
      tick(1);
      clr = '0;
      tick(2);
      chk({err, diag}, 11'h000);
      ev = 10'h001;
      clr = 10'h001;
      tick(1);
      ev = '0;
      clr = '0;
      tick(2);
      chk({err, diag}, 11'h401);
      msk = 10'h001;
      tick(2);
      chk({err, diag}, 11'h001);
      sup = 1'b0;
      tick(4);
      chk({6'h00, diag}, 16'h0000);
      sup = 1'b1;
      msk = '0;
      tick(3);
   endtask

   task automatic t_lock;
      en = 1'b0;
      ev = 10'h100;
      tick(1);
      ev = '0;
      wfail = 1'b1;
      tick(1);
      wfail = 1'b0;
      scan = 1'b1;
      tick(1);
      scan = 1'b0;
      tick(2);
      chk({lock, uoe, loe}, 3'h4);
      lrel = 1'b1;
      en = 1'b1;
      tick(1);
      lrel = 1'b0;
      scan = 1'b1;
      tick(1);
      scan = 1'b0;
      tick(2);
      chk({lock, uoe, loe, err}, 4'h1);
      en = 1'b0;
      tick(2);
   endtask

   task automatic t_tone;
      slp = 1'b1;
      scan = 1'b1;
      tick(1);
      scan = 1'b0;
      chk({uoe, loe, utx, ltx}, 4'hF);
      cyc = 0;
      per = 0;
      prev = 1'b0;
      while (uoe === 1'b1 && cyc < 70000)
      begin
         if (utx === 1'b1 && !prev)
            per++;
         prev = utx;
         cyc++;
         scan = (cyc == 100);
         tick(1);
      end
      chk(16'(cyc), 16'(fesig_pkg::TONE_TOTAL_CYC));
      chk(16'(per), 16'h0020);
      chk({rsl, rnm, loe}, 3'h4);
      slp = 1'b0;
   endtask

   task automatic t_rx;
      do_reset();
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(8100);
      chk({uoe, loe}, 2'h0);
      tick(3100);
   endtask

   task automatic t_dir;
      nop = 1'b1;
      prx = 2'h1;
      fwd = 1'b1;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(8100);
      chk({uoe, loe}, 2'h0);
      nop = 1'b0;
      prx = 2'h3;
   endtask

   task automatic t_wake;
      slp = 1'b1;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      cyc = 0;
      while (wreq !== 1'b1 && cyc < 20)
      begin
         cyc++;
         tick(1);
      end
      chk(wreq, 1'b1);
      slp = 1'b0;
      while (uoe !== 1'b1 && cyc < 9000)
      begin
         cyc++;
         tick(1);
      end
      chk(cyc >= 5990 && cyc <= 6020, 1'b1);
      chk({uoe, loe, ltx}, 3'h7);
   endtask

   initial
   begin
      do_reset();
      chk({err, uoe, loe, lock, diag}, 14'h0000);
      t_err_pin();
      t_lock();
      t_tone();
      t_rx();
      t_dir();
      t_wake();
      test_done();
   end
endmodule

`default_nettype wire
